// file: include/cs_gen_pkg.sv
/*
 Constants for the channel status and subcode generator: register map,
 field positions, reset values, timing counts and sync patterns.
 Assumes a 100 MHz system clock; no other package is needed.
*/
package cs_gen_pkg;
   // System clock
   localparam int CLK_MHZ = 100;
   // Biphase half cell, 354 ns cell split in two; longest time rounds down
   localparam int HALF_CELL_NS = 177;
   localparam int HALF_CELL_CYC = (HALF_CELL_NS * CLK_MHZ) / 1000;
   // Quiet time before a subcode line counts as constant, one word period
   localparam int IDLE_US = 136;
   localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
   // Output block and word shape
   localparam int WORDS_PER_BLOCK = 384;
   localparam int CS_BITS = 192;
   localparam int HALVES_PER_WORD = 64;
   localparam int SYNC_HALVES = 8;
   localparam int SUB_WORD_BITS = 10;
   localparam int CTL_BITS = 4;
   localparam int FIFO_DEPTH = 16;
   // Sync patterns, first half cell in the msb
   localparam logic [7:0] SYNC_B = 8'he8;
   localparam logic [7:0] SYNC_M = 8'he2;
   localparam logic [7:0] SYNC_W = 8'he4;
   // Subcode word layout, first received bit in the msb
   localparam int SUB_SYNC_POS = 9;
   localparam int SUB_CRC_POS = 8;
   localparam int SUB_Q_POS = 6;
   // Channel status positions, zero based
   localparam int CS_CTL_SCL_POS = 2;
   localparam int CS_CAT_POS = 8;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CONTROL_BITS = 8'h08;
   // Control register fields
   localparam int CTRL_ENABLE_POS = 0;
   localparam logic CTRL_ENABLE_RST = 1'b0;
   // Status register fields
   localparam int ST_PRESENT_POS = 0;
   localparam int ST_DATA_OK_POS = 1;
   localparam int ST_CRC_OK_POS = 2;
   localparam int ST_OVF_POS = 3;
   localparam int ST_BCLK_POS = 4;
   localparam int ST_LEVEL_POS = 8;
endpackage : cs_gen_pkg

// file: core/sub_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module sub_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Fill side
   input wire logic wr_valid,
   input wire logic [WIDTH-1:0] wr_data,
   output logic wr_ready,
   // Drain side
   output logic rd_valid,
   output logic [WIDTH-1:0] rd_data,
   input wire logic rd_ready,
   // Fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
         $error("sub_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] cnt_r;
   logic do_wr;
   logic do_rd;

   assign wr_ready = (cnt_r != DEPTH[AW:0]);
   assign rd_valid = (cnt_r != '0);
   assign rd_data = mem[rptr_r];
   assign level = cnt_r;
   assign do_wr = wr_valid && wr_ready;
   assign do_rd = rd_valid && rd_ready;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            mem[wptr_r] <= wr_data;
            wptr_r <= wptr_r + 1'b1;
         end
         if (do_rd)
            rptr_r <= rptr_r + 1'b1;
         if (do_wr && !do_rd)
            cnt_r <= cnt_r + 1'b1;
         else if (do_rd && !do_wr)
            cnt_r <= cnt_r - 1'b1;
      end
   end

   fifo_bound_a: assert property (@(posedge clk) disable iff (reset) cnt_r <= DEPTH)
      else $error("fifo level beyond depth");
endmodule : sub_fifo
`default_nettype wire

// file: core/channel_status_subcode_gen.sv
/*
 Channel status and subcode generator: subcode capture, presence
 detection, channel status selection and biphase-mark word output,
 with a classic Wishbone register slave.
 Assumes all pins are synchronous to clk and pads pull idle lines.
*/
`timescale 1ns/10ps
`default_nettype none
module channel_status_subcode_gen #(
   parameter int IDLE_CYC = cs_gen_pkg::IDLE_CYC,
   parameter int FIFO_DEPTH = cs_gen_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Decoder chip pins
   input wire logic subcode_burst_clock,
   input wire logic subcode_serial_data,
   input wire logic sample_error_flag_in,
   input wire logic audio_input_bit_clock,
   // Digital audio output
   output logic biphase_audio_out
);
   localparam int IW = $clog2(IDLE_CYC + 1);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   localparam int HC = cs_gen_pkg::HALF_CELL_CYC;
   localparam int SW = cs_gen_pkg::SUB_WORD_BITS;
   initial
   begin
      if (IDLE_CYC < 2 || HC < 2 || FIFO_DEPTH < 2)
         $error("channel_status_subcode_gen: counts too small");
   end

   typedef enum logic [2:0] {
      ENG_IDLE = 3'b001,
      ENG_SYNC = 3'b010,
      ENG_DATA = 3'b100
   } eng_t;

   typedef struct packed {
      eng_t eng;
      logic ack;
      logic [31:0] dat;
      logic enable;
      logic ovf;
      logic scl_d;
      logic sda_d;
      logic [IW-1:0] clk_idle;
      logic [IW-1:0] dat_idle;
      logic [SW-1:0] shifter;
      logic [3:0] sh_cnt;
      logic [SW-1:0] holder;
      logic pend;
      logic prev_sync;
      logic [2:0] wq;
      logic [3:0] ctl_acc;
      logic [3:0] ctl;
      logic crc_ok;
      logic [4:0] tmr;
      logic [5:0] half;
      logic [8:0] word;
      logic [7:0] cs_idx;
      logic [31:0] frame;
      logic [7:0] spat;
      logic pol;
      logic line;
      logic [SW-1:0] user_sr;
      logic [3:0] user_cnt;
   } st_t;

   st_t s_r;
   st_t s_nxt;

   logic present;
   logic data_ok;
   logic half_tick;
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic [SW-1:0] fifo_rd_data;
   logic fifo_rd_ready;
   logic [LW-1:0] fifo_level;
   logic [31:0] status_word;

   // Pads pull data and flag low, clocks high, so open pins read absent
   assign present = (s_r.clk_idle != IDLE_CYC[IW-1:0]);
   assign data_ok = (s_r.dat_idle != IDLE_CYC[IW-1:0]);
   assign half_tick = (s_r.tmr == 5'(HC - 1));

   // Channel status bit for one index
   function automatic logic cs_bit(input logic [7:0] idx, input logic pres,
                                   input logic dok, input logic [3:0] ctl,
                                   input logic scl);
      logic b;
      b = 1'b0;
      if (!pres)
         b = (idx == 8'(cs_gen_pkg::CS_CTL_SCL_POS)) ? scl : 1'b0;
      else if (idx < 8'(cs_gen_pkg::CTL_BITS))
         b = dok ? ctl[3 - idx[1:0]] : 1'b0;
      else if (idx == 8'(cs_gen_pkg::CS_CAT_POS))
         b = 1'b1;
      return b;
   endfunction : cs_bit

   // Word bits 1..32 in positions 0..31; even parity over bits 5..31
   function automatic logic [31:0] build_frame(input logic cs, input logic user,
                                               input logic err);
      logic [31:0] f;
      f = '0;
      f[28] = err;
      f[29] = user;
      f[30] = cs;
      f[31] = ^f[30:4];
      return f;
   endfunction : build_frame

   always_comb
   begin
      logic start;
      logic ubit;
      logic [8:0] nw;
      logic [5:0] nh;
      logic [7:0] pat;
      logic [SW-1:0] w;
      start = 1'b0;
      ubit = 1'b0;
      nw = '0;
      nh = '0;
      pat = '0;
      w = '0;
      s_nxt = s_r;
      fifo_rd_ready = 1'b0;

      // Wishbone slave, one wait state, ack drops after one cycle
      s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
      s_nxt.dat = '0;
      if (wb_cyc_i && wb_stb_i && !s_r.ack)
      begin
         if (wb_we_i && wb_sel_i[0])
         begin
            if (wb_adr_i == cs_gen_pkg::REG_CTRL)
               s_nxt.enable = wb_dat_i[cs_gen_pkg::CTRL_ENABLE_POS];
            if (wb_adr_i == cs_gen_pkg::REG_STATUS && wb_dat_i[cs_gen_pkg::ST_OVF_POS])
               s_nxt.ovf = 1'b0;
         end
         unique case (wb_adr_i)
            cs_gen_pkg::REG_CTRL: s_nxt.dat = 32'(s_r.enable);
            cs_gen_pkg::REG_STATUS: s_nxt.dat = status_word;
            cs_gen_pkg::REG_CONTROL_BITS: s_nxt.dat = 32'(s_r.ctl);
            default: s_nxt.dat = '0;
         endcase
      end

      // Line activity; inputs are already synchronous
      s_nxt.scl_d = subcode_burst_clock;
      s_nxt.sda_d = subcode_serial_data;
      if (subcode_burst_clock != s_r.scl_d)
         s_nxt.clk_idle = '0;
      else if (present)
         s_nxt.clk_idle = s_r.clk_idle + 1'b1;
      if (subcode_serial_data != s_r.sda_d)
         s_nxt.dat_idle = '0;
      else if (data_ok)
         s_nxt.dat_idle = s_r.dat_idle + 1'b1;

      // Push first, so a word completing in the same cycle stays pending
      if (s_r.pend && fifo_wr_ready)
         s_nxt.pend = 1'b0;
      // Subcode word capture on burst clock rising edge
      if (!present)
      begin
         s_nxt.shifter = '0;
         s_nxt.sh_cnt = '0;
      end
      else if (subcode_burst_clock && !s_r.scl_d)
      begin
         w = {s_r.shifter[SW-2:0], subcode_serial_data};
         s_nxt.shifter = w;
         s_nxt.sh_cnt = s_r.sh_cnt + 1'b1;
         if (s_r.sh_cnt == 4'(SW - 1))
         begin
            s_nxt.sh_cnt = '0;
            s_nxt.holder = w;
            s_nxt.pend = 1'b1;
            // A word still waiting for room is overwritten and flagged
            if (s_r.pend && !fifo_wr_ready)
               s_nxt.ovf = 1'b1;
            // Low sync marks the block; the second sync carries CRC
            s_nxt.prev_sync = !w[cs_gen_pkg::SUB_SYNC_POS];
            if (!w[cs_gen_pkg::SUB_SYNC_POS])
            begin
               if (s_r.prev_sync)
                  s_nxt.crc_ok = w[cs_gen_pkg::SUB_CRC_POS];
               s_nxt.wq = '0;
            end
            else if (s_r.wq < 3'(cs_gen_pkg::CTL_BITS))
            begin
               s_nxt.ctl_acc[3 - s_r.wq[1:0]] = w[cs_gen_pkg::SUB_Q_POS];
               s_nxt.wq = s_r.wq + 1'b1;
               if (s_r.wq == 3'(cs_gen_pkg::CTL_BITS - 1))
                  s_nxt.ctl = {s_r.ctl_acc[3:1], w[cs_gen_pkg::SUB_Q_POS]};
            end
         end
      end

      // Half-cell timer derived from the system clock
      s_nxt.tmr = half_tick ? '0 : s_r.tmr + 1'b1;

      unique case (s_r.eng)
         ENG_IDLE:
         begin
            s_nxt.line = 1'b0;
            if (s_r.enable)
            begin
               start = 1'b1;
               nw = '0;
            end
         end
         ENG_SYNC, ENG_DATA:
         begin
            if (!s_r.enable)
               s_nxt.eng = ENG_IDLE;
            else if (half_tick)
            begin
               nh = s_r.half + 1'b1;
               if (s_r.half == 6'(cs_gen_pkg::HALVES_PER_WORD - 1))
               begin
                  start = 1'b1;
                  nw = (s_r.word == 9'(cs_gen_pkg::WORDS_PER_BLOCK - 1)) ? '0 : s_r.word + 1'b1;
               end
               else if (nh < 6'(cs_gen_pkg::SYNC_HALVES))
                  s_nxt.line = s_r.spat[3'(7 - nh)] ^ s_r.pol;
               else
               begin
                  s_nxt.eng = ENG_DATA;
                  // Transition at every cell edge, and mid-cell for a one
                  if (!nh[0] || s_r.frame[nh[5:1]])
                     s_nxt.line = !s_r.line;
               end
               s_nxt.half = nh;
            end
         end
         default: s_nxt.eng = ENG_IDLE;
      endcase

      if (start)
      begin
         // FIFO drained one bit per output word into the user bit
         if (s_r.user_cnt != '0)
         begin
            ubit = s_r.user_sr[SW-1];
            s_nxt.user_sr = s_r.user_sr << 1;
            s_nxt.user_cnt = s_r.user_cnt - 1'b1;
         end
         else if (fifo_rd_valid)
         begin
            fifo_rd_ready = 1'b1;
            ubit = fifo_rd_data[SW-1];
            s_nxt.user_sr = fifo_rd_data << 1;
            s_nxt.user_cnt = 4'(SW - 1);
         end
         if (nw == '0)
            pat = cs_gen_pkg::SYNC_B;
         else
            pat = nw[0] ? cs_gen_pkg::SYNC_W : cs_gen_pkg::SYNC_M;
         s_nxt.eng = ENG_SYNC;
         s_nxt.word = nw;
         s_nxt.cs_idx = nw[8:1];
         s_nxt.half = '0;
         s_nxt.tmr = '0;
         s_nxt.spat = pat;
         s_nxt.pol = s_r.line;
         s_nxt.line = pat[7] ^ s_r.line;
         s_nxt.frame = build_frame(cs_bit(nw[8:1], present, data_ok, s_r.ctl,
                                          subcode_burst_clock), ubit,
                                   sample_error_flag_in);
      end
   end

   always_comb
   begin
      status_word = '0;
      status_word[cs_gen_pkg::ST_PRESENT_POS] = present;
      status_word[cs_gen_pkg::ST_DATA_OK_POS] = data_ok;
      status_word[cs_gen_pkg::ST_CRC_OK_POS] = s_r.crc_ok;
      status_word[cs_gen_pkg::ST_OVF_POS] = s_r.ovf;
      status_word[cs_gen_pkg::ST_BCLK_POS] = audio_input_bit_clock;
      status_word[cs_gen_pkg::ST_LEVEL_POS +: LW] = fifo_level;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s_r <= '0;
         s_r.eng <= ENG_IDLE;
         s_r.enable <= cs_gen_pkg::CTRL_ENABLE_RST;
         s_r.scl_d <= 1'b1;
         s_r.clk_idle <= IDLE_CYC[IW-1:0];
         s_r.dat_idle <= IDLE_CYC[IW-1:0];
      end
      else
         s_r <= s_nxt;
   end

   sub_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset(reset),
      .wr_valid(s_r.pend),
      .wr_data(s_r.holder),
      .wr_ready(fifo_wr_ready),
      .rd_valid(fifo_rd_valid),
      .rd_data(fifo_rd_data),
      .rd_ready(fifo_rd_ready),
      .level(fifo_level)
   );

   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.dat;
   assign biphase_audio_out = s_r.line;

   sequence bus_req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence word_wrap_s;
      half_tick && s_r.half == 6'd63 && s_r.eng == ENG_DATA && s_r.enable;
   endsequence

   ack_timing_a: assert property (@(posedge clk) disable iff (reset)
      bus_req_s |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not given after one cycle");
   clock_absent_a: assert property (@(posedge clk) disable iff (reset)
      subcode_burst_clock == s_r.scl_d && s_r.clk_idle == IW'(IDLE_CYC - 1)
      |=> !present)
      else $error("constant burst clock not declared absent");
   shifter_clear_a: assert property (@(posedge clk) disable iff (reset)
      !present |=> s_r.shifter == '0 && s_r.sh_cnt == '0)
      else $error("shifter not cleared without clocks");
   transfer_ten_a: assert property (@(posedge clk) disable iff (reset)
      $changed(s_r.holder) |-> $past(s_r.sh_cnt) == 4'd9)
      else $error("holder loaded before ten clocks");
   line_timing_a: assert property (@(posedge clk) disable iff (reset)
      $changed(biphase_audio_out) && $past(s_r.eng) != ENG_IDLE
      |-> $past(half_tick) || !$past(s_r.enable))
      else $error("output changed off a half-cell edge");
   block_sync_a: assert property (@(posedge clk) disable iff (reset)
      word_wrap_s and (s_r.word == 9'd383) |=> s_r.spat == 8'he8 && s_r.word == '0)
      else $error("block start without pattern B");
   pair_index_a: assert property (@(posedge clk) disable iff (reset)
      word_wrap_s and (s_r.word[0] && s_r.word != 9'd383)
      |=> s_r.cs_idx == $past(s_r.cs_idx) + 1'b1)
      else $error("status index did not advance per pair");
   same_status_a: assert property (@(posedge clk) disable iff (reset)
      word_wrap_s and (!s_r.word[0]) |=> s_r.cs_idx == $past(s_r.cs_idx))
      else $error("status index changed inside a pair");
   category_bit_a: assert property (@(posedge clk) disable iff (reset)
      word_wrap_s and ((s_r.word == 9'd15 || s_r.word == 9'd16) && present)
      |=> s_r.frame[30])
      else $error("CD category bit missing");
   absent_fmt_a: assert property (@(posedge clk) disable iff (reset)
      word_wrap_s and (!present && s_r.word != 9'd3 && s_r.word != 9'd4)
      |=> !s_r.frame[30])
      else $error("general format bit not zero");
   data_const_a: assert property (@(posedge clk) disable iff (reset)
      word_wrap_s and (present && !data_ok && (s_r.word == 9'd383 || s_r.word[8:1] < 8'd3))
      |=> !s_r.frame[30])
      else $error("control bit set with constant data");
endmodule : channel_status_subcode_gen
`default_nettype wire

// file: tb/subcode_source.sv
/*
 Decoder chip model: subcode bursts, sync and CRC words, audio bit clock.
 Assumes the bench calls its tasks; idle lines rest at their pull levels.
*/
`timescale 1ns/10ps
`default_nettype none
module subcode_source (
   // Clock
   input wire logic clk,
   // Decoder pins
   output logic burst_clk,
   output logic burst_data,
   output wire logic bit_clk
);
   logic [1:0] div_r = 2'h0;
   initial
   begin
      burst_clk = 1'b1;
      burst_data = 1'b0;
   end
   // Quarter of the clock, the only other legal ratio being an eighth
   always @(posedge clk) div_r <= div_r + 2'h1;
   assign bit_clk = div_r[1];
   // 36 cycles a bit gives 2.78 MHz, close to nominal
   task automatic send_word(input logic [9:0] w, input int nbits);
      for (int i = 9; i > 9 - nbits; i--)
      begin
         @(posedge clk);
         burst_clk <= 1'b0;
         burst_data <= w[i];
         repeat (18) @(posedge clk);
         burst_clk <= 1'b1;
         repeat (17) @(posedge clk);
      end
      burst_data <= 1'b0; // Released line falls to its pull-down
      repeat (100) @(posedge clk);
   endtask : send_word
   task automatic send_block(input logic crc, input logic [3:0] ctl);
      send_word(10'h0aa, 10);
      send_word({1'b0, crc, 8'haa}, 10);
      for (int i = 3; i >= 0; i--)
         send_word({1'b1, 1'b0, 1'b1, ctl[i], 6'h2a}, 10);
   endtask : send_block
endmodule : subcode_source
`default_nettype wire

// file: tb/channel_status_subcode_gen_bench.sv
/*
 Self-checking bench: registers, subcode capture, FIFO fill and drain,
 decoding of the biphase output in each channel status format.
 Assumes the subcode_source model on the decoder pins.
*/
`timescale 1ns/10ps
`default_nettype none
module channel_status_subcode_gen_bench;
   localparam int NW = 18;
   // User bits of the first two queued subcode words, msb first
   localparam logic [NW-1:0] USER_EXP = 18'h0aa6a;
   logic clk;
   logic reset = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic err_flag = 1'b0;
   logic biphase_audio_out;
   wire logic burst_clk;
   wire logic burst_data;
   wire logic bit_clk;
   logic [63:0] halves [0:NW-1];
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   // Short idle count and shallow FIFO keep the run brief
   channel_status_subcode_gen #(.IDLE_CYC(1000), .FIFO_DEPTH(2)) dut_u (
      .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .subcode_burst_clock(burst_clk),
      .subcode_serial_data(burst_data), .sample_error_flag_in(err_flag),
      .audio_input_bit_clock(bit_clk), .biphase_audio_out(biphase_audio_out));
   subcode_source src_u (.clk(clk), .burst_clk(burst_clk), .burst_data(burst_data),
      .bit_clk(bit_clk));
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : cmp_val
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask : cmp_bit
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
      input logic [3:0] sel, output logic [31:0] rd);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_dat <= dat;
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] r;
      wb(1'b1, adr, dat, 4'hf, r);
   endtask : wr
   task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] mask,
      input logic [31:0] exp);
      logic [31:0] r;
      wb(1'b0, adr, 32'h0, 4'hf, r);
      cmp_val(what, exp, r & mask);
   endtask : rd_chk
   // Samples the middle of every 17-cycle half cell from the first rise
   task automatic grab();
      int k;
      k = 0;
      while (biphase_audio_out !== 1'b1 && k < 200)
      begin
         @(posedge clk);
         k++;
      end
      repeat (7) @(posedge clk);
      for (int w = 0; w < NW; w++)
         for (int h = 0; h < 64; h++)
         begin
            if (w != 0 || h != 0)
               repeat (17) @(posedge clk);
            halves[w][63-h] = biphase_audio_out;
         end
   endtask : grab
   task automatic check_words(input int mode, input logic [3:0] ctl, input logic lvl,
      input logic err);
      logic [32:1] b;
      logic [7:0] s;
      logic prev;
      logic edges;
      logic e;
      for (int w = 0; w < NW; w++)
      begin
         prev = (w == 0) ? 1'b0 : halves[w-1][0];
         s = (w == 0) ? cs_gen_pkg::SYNC_B : (w % 2 == 1) ? cs_gen_pkg::SYNC_W : cs_gen_pkg::SYNC_M;
         if (mode == 0)
            e = (w / 2 < 4) ? ctl[3-w/2] : (w / 2 == 8);
         else if (mode == 1)
            e = (w / 2 == 8);
         else
            e = (w / 2 == 2) & lvl;
         b = 32'h0;
         edges = 1'b1;
         for (int k = 5; k <= 32; k++)
         begin
            b[k] = halves[w][65-2*k] ^ halves[w][64-2*k];
            if (halves[w][65-2*k] === halves[w][66-2*k])
               edges = 1'b0;
         end
         cmp_val("sync pattern", {24'h0, s}, {24'h0, halves[w][63:56] ^ {8{prev}}});
         cmp_bit("cell edges", 1'b1, edges);
         cmp_val("unused bits", 32'h0, {8'h0, b[28:5]});
         cmp_bit("valid bit", err, b[29]);
         if (mode == 0)
            cmp_bit("user bit", USER_EXP[NW-1-w], b[30]);
         cmp_bit("status bit", e, b[31]);
         cmp_bit("parity", 1'b0, ^b[32:5]);
      end
   endtask : check_words
   task automatic t_reset();
      logic [31:0] r;
      rd_chk("ctrl", cs_gen_pkg::REG_CTRL, 32'h1, 32'h0);
      rd_chk("status", cs_gen_pkg::REG_STATUS, 32'h1f0b, 32'h0);
      rd_chk("control bits", cs_gen_pkg::REG_CONTROL_BITS, 32'hf, 32'h0);
      rd_chk("unmapped", 8'h0c, 32'hffffffff, 32'h0);
      wb(1'b1, cs_gen_pkg::REG_CTRL, 32'h1, 4'h0, r);
      rd_chk("ctrl no lane", cs_gen_pkg::REG_CTRL, 32'h1, 32'h0);
      cmp_bit("line idle", 1'b0, biphase_audio_out);
      $display("test reset done");
   endtask : t_reset
   task automatic t_present();
      logic [31:0] r;
      src_u.send_word(10'h3ff, 5);
      repeat (1200) @(posedge clk);
      src_u.send_block(1'b1, 4'h9);
      rd_chk("status full", cs_gen_pkg::REG_STATUS, 32'h1f0f, 32'h020f);
      rd_chk("control bits", cs_gen_pkg::REG_CONTROL_BITS, 32'hf, 32'h9);
      wb(1'b1, cs_gen_pkg::REG_STATUS, 32'h8, 4'h1, r);
      rd_chk("overflow cleared", cs_gen_pkg::REG_STATUS, 32'h1f08, 32'h0200);
      wr(cs_gen_pkg::REG_CTRL, 32'h1);
      fork
         grab();
         repeat (7) src_u.send_block(1'b1, 4'h9);
      join
      check_words(0, 4'h9, 1'b0, 1'b0);
      $display("test subcode present done");
   endtask : t_present
   task automatic t_const();
      err_flag <= 1'b1;
      wr(cs_gen_pkg::REG_CTRL, 32'h0);
      repeat (3) src_u.send_word(10'h000, 10);
      rd_chk("status constant", cs_gen_pkg::REG_STATUS, 32'h7, 32'h1);
      wr(cs_gen_pkg::REG_CTRL, 32'h1);
      fork
         grab();
         repeat (42) src_u.send_word(10'h000, 10);
      join
      check_words(1, 4'h0, 1'b0, 1'b1);
      $display("test constant data done");
   endtask : t_const
   task automatic t_absent();
      logic [31:0] r;
      int k;
      err_flag <= 1'b0;
      wr(cs_gen_pkg::REG_CTRL, 32'h0);
      repeat (1200) @(posedge clk);
      rd_chk("status absent", cs_gen_pkg::REG_STATUS, 32'h1, 32'h0);
      wr(cs_gen_pkg::REG_CTRL, 32'h1);
      grab();
      check_words(2, 4'h0, 1'b1, 1'b0);
      k = 0;
      do
      begin
         repeat (1000) @(posedge clk);
         wb(1'b0, cs_gen_pkg::REG_STATUS, 32'h0, 4'hf, r);
         k++;
      end
      while (r[12:8] !== 5'h0 && k < 40);
      cmp_val("fifo drained", 32'h0, {27'h0, r[12:8]});
      $display("test subcode absent done");
   endtask : t_absent
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard, above the roughly 73000 cycles the tests need
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 100000)
      begin
         errors++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_present();
      t_const();
      t_absent();
      tally_and_finish();
   end
endmodule : channel_status_subcode_gen_bench
`default_nettype wire
